// ===== mcxa_pkg.sv
// Purpose: shared constants, types and helpers for the 8-bit execution core
// Assumes: one clock, synchronous active-low reset, decoded ops as input
// Notes:   instruction encodings and port strobe timing live elsewhere
// Function
// - probe with constant sets ZERO on zero AND
// - probe loads CARRY with odd parity of AND
// - probe writes no general-purpose register
// - register probe ANDs two registers, same flags
// - XOR with constant writes back, clears CARRY
// - XOR of two registers writes back, clears CARRY
// - sixteen 8-bit registers, 4-bit register number
// - 1024 x 18 code space, 10-bit location
// - immediate constants are 8 bits wide
// - 256 ports, 8-bit number, only INPUT/OUTPUT
// - 64-byte scratch RAM, only STORE/FETCH
// - 31x10 stack, call/interrupt push, returns pop
// - only flow ops and interrupt entry load non-sequential PC
// - logic ops set ZERO on zero result
// - plain return loads stack top plus one
package mcxa_pkg;

	// ------------------------------------------------------------
	// address spaces
	// ------------------------------------------------------------
	localparam int DATA_W      = 8;
	localparam int REG_CNT     = 16;
	localparam int REG_IDX_W   = 4;
	localparam int PC_W        = 10;
	localparam int CODE_DEPTH  = 1024;
	// code word width; the code memory itself sits outside this core
	localparam int INSTR_W     = 18;
	localparam int RAM_DEPTH   = 64;
	localparam int RAM_ADDR_W  = 6;
	localparam int PORT_W      = 8;
	localparam int STACK_DEPTH = 31;
	localparam int STACK_PTR_W = 5;

	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0]      ZERO_BYTE    = 8'h00;
	localparam logic [PC_W-1:0]        PC_STEP      = 10'h001;
	localparam logic [PC_W-1:0]        RESET_VECTOR = 10'h000;
	localparam logic [PC_W-1:0]        INT_VECTOR   = 10'h3FF;
	localparam logic [STACK_PTR_W-1:0] PTR_ZERO     = 5'h00;
	localparam logic [STACK_PTR_W-1:0] PTR_STEP     = 5'h01;
	localparam logic [STACK_PTR_W-1:0] PTR_LAST     = 5'h1E;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_LOAD_K   = 5'h01,
		OP_LOAD_R   = 5'h02,
		OP_PROBE_K  = 5'h03,
		OP_PROBE_R  = 5'h04,
		OP_XOR_K    = 5'h05,
		OP_XOR_R    = 5'h06,
		OP_JUMP     = 5'h07,
		OP_CALL     = 5'h08,
		OP_RETURN   = 5'h09,
		OP_RETI_DIS = 5'h0A,
		OP_RETI_EN  = 5'h0B,
		OP_STORE_D  = 5'h0C,
		OP_STORE_I  = 5'h0D,
		OP_FETCH_D  = 5'h0E,
		OP_FETCH_I  = 5'h0F,
		OP_INPUT_D  = 5'h10,
		OP_INPUT_I  = 5'h11,
		OP_OUTPUT_D = 5'h12,
		OP_OUTPUT_I = 5'h13,
		OP_INT_EN   = 5'h14,
		OP_INT_DIS  = 5'h15
	} mcxa_op_t;

	typedef enum logic [2:0] {
		COND_ALWAYS = 3'h0,
		COND_Z      = 3'h1,
		COND_NZ     = 3'h2,
		COND_C      = 3'h3,
		COND_NC     = 3'h4
	} mcxa_cond_t;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_RUN  = 2'b01
	} mcxa_state_t;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic odd_parity(input logic [DATA_W-1:0] v);
		return ^v;
	endfunction

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == ZERO_BYTE;
	endfunction

	function automatic logic cond_met(input mcxa_cond_t c,
		input logic z, input logic cy);
		logic r;
		r = 1'b1;
		case (c)
			COND_Z:  r = z;
			COND_NZ: r = !z;
			COND_C:  r = cy;
			COND_NC: r = !cy;
			default: r = 1'b1;
		endcase
		return r;
	endfunction

endpackage

// ===== mcxa_regfile.sv
// Purpose: general-purpose register file, two read ports, one write
// Assumes: write lands at the clock edge, reads are combinational
// Notes:   cleared on reset so simulations start from a known file
`timescale 1ns/1ps
module mcxa_regfile import mcxa_pkg::*; #(
	parameter int COUNT = REG_CNT,
	parameter int IDX_W = REG_IDX_W
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic [IDX_W-1:0]  rd_a_idx,
	input  wire logic [IDX_W-1:0]  rd_b_idx,
	output logic      [DATA_W-1:0] rd_a_data,
	output logic      [DATA_W-1:0] rd_b_data,
	input  wire logic              wr_en,
	input  wire logic [IDX_W-1:0]  wr_idx,
	input  wire logic [DATA_W-1:0] wr_data
);

	logic [DATA_W-1:0] regs_q [COUNT];

	// direct addressing, register 0 through COUNT-1
	assign rd_a_data = regs_q[rd_a_idx];
	assign rd_b_data = regs_q[rd_b_idx];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < COUNT; i++) begin
				regs_q[i] <= ZERO_BYTE;
			end
		end else if (wr_en) begin
			regs_q[wr_idx] <= wr_data;
		end
	end

endmodule // mcxa_regfile

// ===== mcxa_stack.sv
// Purpose: call/return stack of code locations
// Assumes: push and pop never come in the same cycle
// Notes:   circular; a push past the depth overwrites the oldest entry
`timescale 1ns/1ps
module mcxa_stack import mcxa_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	input  wire logic            clock,
	input  wire logic            rstn,
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [PC_W-1:0] push_value,
	output logic      [PC_W-1:0] stack_top_value
);

	logic [PC_W-1:0]        mem_q [DEPTH];
	logic [STACK_PTR_W-1:0] ptr_q;
	logic [STACK_PTR_W-1:0] ptr_d;
	logic [STACK_PTR_W-1:0] top_idx;

	assign top_idx = (ptr_q == PTR_ZERO) ? PTR_LAST : ptr_q - PTR_STEP;
	assign stack_top_value = mem_q[top_idx];

	always_comb begin
		ptr_d = ptr_q;
		if (push) begin
			ptr_d = (ptr_q == PTR_LAST) ? PTR_ZERO : ptr_q + PTR_STEP;
		end else if (pop) begin
			ptr_d = top_idx;
		end
	end

	// reset empties the stack by rewinding the pointer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ptr_q <= PTR_ZERO;
		end else begin
			ptr_q <= ptr_d;
			if (push) begin
				mem_q[ptr_q] <= push_value;
			end
		end
	end

endmodule // mcxa_stack

// ===== mcxa_core.sv
// Purpose: executes decoded ops against the five address spaces
// Assumes: one op per clock while op_valid; code memory is external
// Notes:   interrupt takes priority over the op offered that cycle
`timescale 1ns/1ps
module mcxa_core import mcxa_pkg::*; (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  op_valid,
	input  wire mcxa_op_t              op_code,
	input  wire mcxa_cond_t            op_cond,
	input  wire logic [REG_IDX_W-1:0]  first_operand_register,
	input  wire logic [REG_IDX_W-1:0]  second_operand_register,
	input  wire logic [DATA_W-1:0]     immediate_constant,
	input  wire logic [PORT_W-1:0]     port_number,
	input  wire logic [RAM_ADDR_W-1:0] ram_location,
	input  wire logic [PC_W-1:0]       code_location,
	input  wire logic [DATA_W-1:0]     in_port,
	input  wire logic                  interrupt,
	output logic      [PC_W-1:0]       code_address,
	output logic                       zero_flag,
	output logic                       carry_flag,
	output logic                       interrupt_enable,
	output logic                       interrupt_ack,
	output logic      [PORT_W-1:0]     port_id,
	output logic      [DATA_W-1:0]     out_port,
	output logic                       write_strobe,
	output logic                       read_strobe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mcxa_state_t       state_q, state_d;
	logic [PC_W-1:0]   pc_q, pc_d;
	logic              zero_q, zero_d, carry_q, carry_d;
	logic              saved_zero_q, saved_zero_d;
	logic              saved_carry_q, saved_carry_d;
	logic              ie_q, ie_d, ack_q, ack_d;
	logic [PORT_W-1:0] port_id_q, port_id_d;
	logic [DATA_W-1:0] out_port_q, out_port_d;
	logic              wstb_q, wstb_d, rstb_q, rstb_d;

	logic [DATA_W-1:0] ram_q [RAM_DEPTH];

	logic [DATA_W-1:0]     reg_a, reg_b, operand, probe_val, xor_val;
	logic                  rf_we;
	logic [DATA_W-1:0]     rf_wd;
	logic                  st_push, st_pop;
	logic [PC_W-1:0]       st_push_val, stack_top_value;
	logic                  ram_we;
	logic [RAM_ADDR_W-1:0] ram_addr;
	logic                  take_int;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	mcxa_regfile u_regfile (
		.clock     (clock),
		.rstn      (rstn),
		.rd_a_idx  (first_operand_register),
		.rd_b_idx  (second_operand_register),
		.rd_a_data (reg_a),
		.rd_b_data (reg_b),
		.wr_en     (rf_we),
		.wr_idx    (first_operand_register),
		.wr_data   (rf_wd)
	);

	mcxa_stack u_stack (
		.clock           (clock),
		.rstn            (rstn),
		.push            (st_push),
		.pop             (st_pop),
		.push_value      (st_push_val),
		.stack_top_value (stack_top_value)
	);

	// ------------------------------------------------------------
	// datapath
	// ------------------------------------------------------------
	always_comb begin
		operand = immediate_constant;
		if (op_code == OP_PROBE_R || op_code == OP_XOR_R ||
			op_code == OP_LOAD_R) begin
			operand = reg_b;
		end
	end

	assign probe_val = reg_a & operand;
	assign xor_val   = reg_a ^ operand;

	// indirect forms use the second register's low bits
	always_comb begin
		ram_addr = ram_location;
		if (op_code == OP_STORE_I || op_code == OP_FETCH_I) begin
			ram_addr = reg_b[RAM_ADDR_W-1:0];
		end
	end

	assign take_int = (state_q == ST_RUN) && interrupt && ie_q;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_d       = state_q;
		pc_d          = pc_q;
		zero_d        = zero_q;
		carry_d       = carry_q;
		saved_zero_d  = saved_zero_q;
		saved_carry_d = saved_carry_q;
		ie_d          = ie_q;
		ack_d         = 1'b0;
		port_id_d     = port_id_q;
		out_port_d    = out_port_q;
		wstb_d        = 1'b0;
		rstb_d        = 1'b0;
		rf_we         = 1'b0;
		rf_wd         = ZERO_BYTE;
		st_push       = 1'b0;
		st_pop        = 1'b0;
		st_push_val   = pc_q;
		ram_we        = 1'b0;
		case (state_q)
			ST_INIT: begin
				pc_d    = RESET_VECTOR;
				state_d = ST_RUN;
			end
			ST_RUN: begin
				if (take_int) begin
					// interrupted op is re-run after the return
					st_push       = 1'b1;
					pc_d          = INT_VECTOR;
					saved_zero_d  = zero_q;
					saved_carry_d = carry_q;
					ie_d          = 1'b0;
					ack_d         = 1'b1;
				end else if (op_valid) begin
					pc_d = pc_q + PC_STEP;
					case (op_code)
						OP_LOAD_K, OP_LOAD_R: begin
							rf_we = 1'b1;
							rf_wd = operand;
						end
						OP_PROBE_K, OP_PROBE_R: begin
							// flags only, no write-back
							zero_d  = is_zero(probe_val);
							carry_d = odd_parity(probe_val);
						end
						OP_XOR_K, OP_XOR_R: begin
							rf_we   = 1'b1;
							rf_wd   = xor_val;
							zero_d  = is_zero(xor_val);
							carry_d = 1'b0;
						end
						OP_JUMP: begin
							if (cond_met(op_cond, zero_q, carry_q)) begin
								pc_d = code_location;
							end
						end
						OP_CALL: begin
							if (cond_met(op_cond, zero_q, carry_q)) begin
								st_push = 1'b1;
								pc_d    = code_location;
							end
						end
						OP_RETURN: begin
							if (cond_met(op_cond, zero_q, carry_q)) begin
								st_pop = 1'b1;
								pc_d   = stack_top_value + PC_STEP;
							end
						end
						OP_RETI_DIS, OP_RETI_EN: begin
							// resumes at the interrupted op itself
							st_pop  = 1'b1;
							pc_d    = stack_top_value;
							zero_d  = saved_zero_q;
							carry_d = saved_carry_q;
							ie_d    = (op_code == OP_RETI_EN);
						end
						OP_STORE_D, OP_STORE_I: begin
							ram_we = 1'b1;
						end
						OP_FETCH_D, OP_FETCH_I: begin
							rf_we = 1'b1;
							rf_wd = ram_q[ram_addr];
						end
						OP_INPUT_D, OP_INPUT_I: begin
							port_id_d = (op_code == OP_INPUT_I) ?
								reg_b : port_number;
							rf_we     = 1'b1;
							rf_wd     = in_port;
							rstb_d    = 1'b1;
						end
						OP_OUTPUT_D, OP_OUTPUT_I: begin
							port_id_d  = (op_code == OP_OUTPUT_I) ?
								reg_b : port_number;
							out_port_d = reg_a;
							wstb_d     = 1'b1;
						end
						OP_INT_EN: ie_d = 1'b1;
						OP_INT_DIS: ie_d = 1'b0;
						default: begin
						end
					endcase
				end
			end
			default: state_d = ST_INIT;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q       <= ST_INIT;
			pc_q          <= RESET_VECTOR;
			zero_q        <= 1'b0;
			carry_q       <= 1'b0;
			saved_zero_q  <= 1'b0;
			saved_carry_q <= 1'b0;
			ie_q          <= 1'b0;
			ack_q         <= 1'b0;
			port_id_q     <= ZERO_BYTE;
			out_port_q    <= ZERO_BYTE;
			wstb_q        <= 1'b0;
			rstb_q        <= 1'b0;
		end else begin
			state_q       <= state_d;
			pc_q          <= pc_d;
			zero_q        <= zero_d;
			carry_q       <= carry_d;
			saved_zero_q  <= saved_zero_d;
			saved_carry_q <= saved_carry_d;
			ie_q          <= ie_d;
			ack_q         <= ack_d;
			port_id_q     <= port_id_d;
			out_port_q    <= out_port_d;
			wstb_q        <= wstb_d;
			rstb_q        <= rstb_d;
		end
	end

	// scratch RAM keeps its contents over reset, like block RAM
	always_ff @(posedge clock) begin
		if (ram_we) begin
			ram_q[ram_addr] <= reg_a;
		end
	end

	assign code_address     = pc_q;
	assign zero_flag        = zero_q;
	assign carry_flag       = carry_q;
	assign interrupt_enable = ie_q;
	assign interrupt_ack    = ack_q;
	assign port_id          = port_id_q;
	assign out_port         = out_port_q;
	assign write_strobe     = wstb_q;
	assign read_strobe      = rstb_q;

endmodule // mcxa_core

// ===== mcxa_core_asserts.sv
// Purpose: concurrent checks on the execution core ports
// Assumes: one clock, synchronous active-low reset
// Notes:   register contents are not visible here, only flags, pc, interrupt enable, port id and strobes
`timescale 1ns/1ps
module mcxa_core_asserts import mcxa_pkg::*; (
	input wire logic                  clock,
	input wire logic                  rstn,
	input wire logic                  op_valid,
	input wire mcxa_op_t              op_code,
	input wire mcxa_cond_t            op_cond,
	input wire logic [REG_IDX_W-1:0]  first_operand_register,
	input wire logic [REG_IDX_W-1:0]  second_operand_register,
	input wire logic [DATA_W-1:0]     immediate_constant,
	input wire logic [PORT_W-1:0]     port_number,
	input wire logic [PC_W-1:0]       code_location,
	input wire logic                  interrupt,
	input wire logic [PC_W-1:0]       code_address,
	input wire logic                  zero_flag,
	input wire logic                  carry_flag,
	input wire logic                  interrupt_enable,
	input wire logic [PORT_W-1:0]     port_id,
	input wire logic                  write_strobe,
	input wire logic                  read_strobe
);
	// ------------------------------------------------------------
	// helper: first edge after reset release is an init cycle
	// ------------------------------------------------------------
	logic run_q;
	logic run_d;
	logic take;
	always_comb run_d = rstn;
	always_ff @(posedge clock) begin
		run_q <= run_d;
	end
	assign take = run_q && op_valid && !(interrupt && interrupt_enable);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_xor_k_carry: assert property (take && op_code == OP_XOR_K |=>
		!carry_flag) else $error("carry not cleared by xor constant");
	a_xor_r_carry: assert property (take && op_code == OP_XOR_R |=>
		!carry_flag) else $error("carry not cleared by xor register");
	a_xor_self_zero: assert property (take && op_code == OP_XOR_R &&
		first_operand_register == second_operand_register |=> zero_flag)
		else $error("xor with itself left zero clear");
	a_probe_nil_mask: assert property (take && op_code == OP_PROBE_K &&
		immediate_constant == ZERO_BYTE |=> zero_flag && !carry_flag)
		else $error("probe with empty mask gave wrong flags");
	a_pc_step_next: assert property (take && op_code inside {OP_LOAD_K,
		OP_PROBE_K, OP_PROBE_R, OP_XOR_K, OP_XOR_R, OP_OUTPUT_D, OP_INPUT_D,
		OP_STORE_D, OP_FETCH_D} |=> code_address == $past(code_address) + PC_STEP)
		else $error("pc did not advance by one");
	a_jump_target_load: assert property (take && op_code == OP_JUMP &&
		op_cond == COND_ALWAYS |=> code_address == $past(code_location))
		else $error("jump target not loaded");
	a_out_port_strobe: assert property (take && op_code == OP_OUTPUT_D |=>
		write_strobe && port_id == $past(port_number))
		else $error("output strobe or port number wrong");
	a_in_read_strobe: assert property (take && op_code == OP_INPUT_D |=>
		read_strobe && !write_strobe) else $error("input strobe wrong");
	a_reset_vector_pc: assert property ($rose(rstn) |->
		code_address == RESET_VECTOR && !zero_flag && !carry_flag)
		else $error("reset state wrong");
	c_probe_reg: cover property (take && op_code == OP_PROBE_R);
	c_xor_const: cover property (take && op_code == OP_XOR_K);
	c_return: cover property (take && op_code == OP_RETURN);
	c_int_taken: cover property (run_q && interrupt && interrupt_enable);
endmodule // mcxa_core_asserts

bind mcxa_core mcxa_core_asserts u_chk (.clock(clock), .rstn(rstn),
	.op_valid(op_valid), .op_code(op_code), .op_cond(op_cond),
	.first_operand_register(first_operand_register),
	.second_operand_register(second_operand_register),
	.immediate_constant(immediate_constant), .port_number(port_number),
	.code_location(code_location), .interrupt(interrupt),
	.code_address(code_address), .zero_flag(zero_flag),
	.carry_flag(carry_flag), .interrupt_enable(interrupt_enable),
	.port_id(port_id), .write_strobe(write_strobe),
	.read_strobe(read_strobe));

// ===== mcu_test_xor_and_address_spaces_test.sv
// Purpose: directed bench for probe, xor and address spaces
// Assumes: registers are seen only through output ops
// Notes:   interrupt input pulsed once in t_irq to cover entry and return
`timescale 1ns/1ps
module mcu_test_xor_and_address_spaces_test import mcxa_pkg::*;;
	logic       clock = 1'b0;
	logic       rstn = 1'b0;
	logic       op_valid = 1'b0;
	mcxa_op_t   op_code = OP_NOP;
	mcxa_cond_t op_cond = COND_ALWAYS;
	logic [3:0] ra = 4'h0;
	logic [3:0] rb = 4'h0;
	logic [7:0] imm = 8'h00;
	logic [7:0] pnum = 8'h00;
	logic [7:0] in_port = 8'h00;
	logic [5:0] ram_loc = 6'h00;
	logic [9:0] code_loc = 10'h000;
	logic       irq = 1'b0;
	logic       ie;
	logic       ack;
	logic [9:0] code_address;
	logic [9:0] pc0;
	logic       zero_flag;
	logic       carry_flag;
	logic       wstb;
	logic       rstb;
	logic [7:0] port_id;
	logic [7:0] out_port;
	int         fail_count = 0;
	int         tests_run = 0;
	int         cycles = 0;

	mcxa_core u_dut (.clock(clock), .rstn(rstn), .op_valid(op_valid),
		.op_code(op_code), .op_cond(op_cond), .first_operand_register(ra),
		.second_operand_register(rb), .immediate_constant(imm),
		.port_number(pnum), .ram_location(ram_loc), .code_location(code_loc),
		.in_port(in_port), .interrupt(irq), .code_address(code_address),
		.zero_flag(zero_flag), .carry_flag(carry_flag),
		.interrupt_enable(ie), .interrupt_ack(ack), .port_id(port_id),
		.out_port(out_port),
		.write_strobe(wstb), .read_strobe(rstb));

	always #10 clock = ~clock;
	// ------------------------------------------------------------
	// common tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [9:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one op per call; results are settled 1 ns after the executing edge
	task automatic run(input mcxa_op_t c, input logic [3:0] a, b,
		input logic [7:0] k, input mcxa_cond_t n = COND_ALWAYS);
		@(posedge clock);
		op_valid <= 1'b1;
		op_code <= c;
		op_cond <= n;
		ra <= a;
		rb <= b;
		imm <= k;
		pnum <= k;
		ram_loc <= k[5:0];
		code_loc <= {2'b11, k};
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic flags(input logic z, cy);
		chk("zero_flag", {9'h000, z}, {9'h000, zero_flag});
		chk("carry_flag", {9'h000, cy}, {9'h000, carry_flag});
	endtask

	task automatic show(input logic [3:0] a, input logic [7:0] exp);
		run(OP_OUTPUT_D, a, 4'h0, 8'h20);
		chk("out_port", {2'b00, exp}, {2'b00, out_port});
		chk("write_strobe", 10'h001, {9'h000, wstb});
	endtask

	task automatic final_report;
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_probe;
		run(OP_LOAD_K, 4'h1, 4'h0, 8'h5A);
		pc0 = code_address;
		run(OP_PROBE_K, 4'h1, 4'h0, 8'h0F);
		flags(1'b0, 1'b0);
		run(OP_PROBE_K, 4'h1, 4'h0, 8'h02);
		flags(1'b0, 1'b1);
		run(OP_PROBE_K, 4'h1, 4'h0, 8'hA5);
		flags(1'b1, 1'b0);
		run(OP_LOAD_K, 4'h2, 4'h0, 8'h4B);
		run(OP_PROBE_R, 4'h1, 4'h2, 8'h00);
		flags(1'b0, 1'b1);
		run(OP_PROBE_R, 4'h1, 4'h3, 8'hFF);
		flags(1'b1, 1'b0);
		show(4'h1, 8'h5A);
		chk("code_address", pc0 + 10'h007, code_address);
	endtask

	task automatic t_xor;
		run(OP_PROBE_K, 4'h1, 4'h0, 8'h02);
		run(OP_XOR_K, 4'h1, 4'h0, 8'hFF);
		flags(1'b0, 1'b0);
		show(4'h1, 8'hA5);
		run(OP_PROBE_K, 4'h1, 4'h0, 8'h01);
		run(OP_XOR_R, 4'h1, 4'h2, 8'h00);
		flags(1'b0, 1'b0);
		show(4'h1, 8'hEE);
		run(OP_PROBE_K, 4'h1, 4'h0, 8'h02);
		run(OP_XOR_R, 4'h1, 4'h1, 8'h00);
		flags(1'b1, 1'b0);
		show(4'h1, 8'h00);
	endtask

	task automatic t_spaces;
		run(OP_LOAD_K, 4'hF, 4'h0, 8'hF0);
		run(OP_LOAD_K, 4'h0, 4'h0, 8'h0F);
		show(4'hF, 8'hF0);
		show(4'h0, 8'h0F);
		run(OP_STORE_D, 4'hF, 4'h0, 8'h3F);
		run(OP_FETCH_D, 4'h3, 4'h0, 8'h3F);
		show(4'h3, 8'hF0);
		in_port <= 8'hC3;
		run(OP_INPUT_D, 4'h4, 4'h0, 8'hFF);
		chk("read_strobe", 10'h001, {9'h000, rstb});
		chk("port_id", 10'h0FF, {2'b00, port_id});
		show(4'h4, 8'hC3);
		run(OP_LOAD_K, 4'h5, 4'h0, 8'h77);
		run(OP_OUTPUT_I, 4'h4, 4'h5, 8'h00);
		chk("port_id", 10'h077, {2'b00, port_id});
		chk("out_port", 10'h0C3, {2'b00, out_port});
	endtask

	// interrupt taken between ops; the return resumes at the skipped location
	task automatic t_irq;
		run(OP_INT_EN, 4'h0, 4'h0, 8'h00);
		chk("interrupt_enable", 10'h001, {9'h000, ie});
		run(OP_PROBE_K, 4'hF, 4'h0, 8'h10);
		pc0 = code_address;
		@(posedge clock);
		irq <= 1'b1;
		@(posedge clock);
		irq <= 1'b0;
		#1;
		chk("code_address", 10'h3FF, code_address);
		chk("interrupt_ack", 10'h001, {9'h000, ack});
		chk("interrupt_enable", 10'h000, {9'h000, ie});
		run(OP_XOR_R, 4'h6, 4'h6, 8'h00);
		flags(1'b1, 1'b0);
		chk("interrupt_ack", 10'h000, {9'h000, ack});
		run(OP_RETI_EN, 4'h0, 4'h0, 8'h00);
		chk("code_address", pc0, code_address);
		flags(1'b0, 1'b1);
		chk("interrupt_enable", 10'h001, {9'h000, ie});
		run(OP_INT_DIS, 4'h0, 4'h0, 8'h00);
	endtask

	task automatic t_flow;
		pc0 = code_address;
		run(OP_CALL, 4'h0, 4'h0, 8'h40);
		chk("code_address", 10'h340, code_address);
		run(OP_NOP, 4'h0, 4'h0, 8'h00);
		run(OP_RETURN, 4'h0, 4'h0, 8'h00);
		chk("code_address", pc0 + 10'h001, code_address);
		run(OP_JUMP, 4'h0, 4'h0, 8'hFF);
		chk("code_address", 10'h3FF, code_address);
		run(OP_NOP, 4'h0, 4'h0, 8'h00);
		chk("code_address", 10'h000, code_address);
	endtask
	// ------------------------------------------------------------
	// sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk("code_address", 10'h000, code_address);
		t_probe();
		t_xor();
		t_spaces();
		t_irq();
		t_flow();
		final_report();
	end
endmodule // mcu_test_xor_and_address_spaces_test
